// file: rtl/iaw_defs.vh
// Constants for the interrupt acceptance and wakeup block
`ifndef IAW_DEFS_VH
`define IAW_DEFS_VH

// Source indices, lowest index has highest priority
`define IAW_NSRC        13
`define IAW_SRC_EXTA    0
`define IAW_SRC_EXTB    1
`define IAW_SRC_CNTA    2
`define IAW_SRC_CNTB    3
`define IAW_SRC_TMRX    4
`define IAW_SRC_TMRY    5
`define IAW_SRC_TMR1    6
`define IAW_SRC_TMR2    7
`define IAW_SRC_SRX     8
`define IAW_SRC_STX     9
`define IAW_SRC_ARB     10
`define IAW_SRC_ADC     11
`define IAW_SRC_KEY     12

// Vector code for software break
`define IAW_VEC_BREAK   4'hD
`define IAW_VEC_W       4

// Program counter step on software break
`define IAW_BRK_PC_INC  16'h0002

// Stack sequencer states
`define IAW_ST_IDLE     3'h0
`define IAW_ST_PCH      3'h1
`define IAW_ST_PCL      3'h2
`define IAW_ST_PS       3'h3
`define IAW_ST_VEC      3'h4
`define IAW_ST_RPS      3'h5
`define IAW_ST_RPCL     3'h6
`define IAW_ST_RPCH     3'h7

// AXI4-Lite register map
`define IAW_REG_REQ     4'h0
`define IAW_REG_EN      4'h4
`define IAW_REG_POL     4'h8
`define IAW_REG_MODE    4'hC
`define IAW_RESP_OKAY   2'h0
`define IAW_RESP_SLVERR 2'h2

// Mode register fields
`define IAW_MODE_TMRX_EVT 0
`define IAW_MODE_TMRY_EVT 1
`define IAW_MODE_SER_EXT  2
`define IAW_MODE_KEY_SEL  3

// Status byte fields restored on return
`define IAW_PS_DIS_BIT    2
`define IAW_PS_BRK_BIT    4

`endif

// file: rtl/iaw_top.v
// Interrupt acceptance, stacking sequencer and wakeup logic
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "iaw_defs.vh"

module iaw_top #(
  parameter KEY_W = 8
) (
  // Clock and reset
  input  wire                 aclk,
  input  wire                 aresetn,
  // AXI4-Lite slave
  input  wire [3:0]           s_awaddr,
  input  wire                 s_awvalid,
  output wire                 s_awready,
  input  wire [31:0]          s_wdata,
  input  wire [3:0]           s_wstrb,
  input  wire                 s_wvalid,
  output wire                 s_wready,
  output reg  [1:0]           s_bresp,
  output reg                  s_bvalid,
  input  wire                 s_bready,
  input  wire [3:0]           s_araddr,
  input  wire                 s_arvalid,
  output wire                 s_arready,
  output reg  [31:0]          s_rdata,
  output reg  [1:0]           s_rresp,
  output reg                  s_rvalid,
  input  wire                 s_rready,
  // External pins
  input  wire                 ext_irq_pin_a,
  input  wire                 ext_irq_pin_b,
  input  wire                 counter_pin_a,
  input  wire                 counter_pin_b,
  input  wire [KEY_W-1:0]     keypad_port,
  // Internal peripheral event pulses
  input  wire                 tmrx_evt,
  input  wire                 tmry_evt,
  input  wire                 tmr1_evt,
  input  wire                 tmr2_evt,
  input  wire                 srx_evt,
  input  wire                 stx_evt,
  input  wire                 arb_evt,
  input  wire                 adc_evt,
  // Core sequencer
  input  wire                 insn_boundary,
  input  wire                 software_break_instruction,
  input  wire                 return_from_interrupt_instruction,
  input  wire                 stop_instruction,
  input  wire                 wait_instruction,
  input  wire                 clr_disable,
  input  wire                 set_disable,
  input  wire [15:0]          pc_in,
  input  wire [7:0]           status_in,
  input  wire [7:0]           pop_data,
  // Core outputs
  output reg                  seq_busy_q,
  output reg                  push_valid_q,
  output reg  [7:0]           push_data_q,
  output reg                  pop_req_q,
  output reg                  vec_valid_q,
  output reg  [`IAW_VEC_W-1:0] vec_q,
  output reg  [15:0]          pc_out_q,
  output reg                  pc_load_q,
  output reg                  disable_q,
  output reg                  break_flag_q,
  output reg                  stop_mode_q,
  output reg                  wait_mode_q
);

  localparam N = `IAW_NSRC;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [4+KEY_W-1:0] pin_s1_q;
  reg [4+KEY_W-1:0] pin_s2_q;
  reg [3:0]         pin_prev_q;
  wire [4+KEY_W-1:0] pins_raw = {keypad_port, counter_pin_b, counter_pin_a, ext_irq_pin_b, ext_irq_pin_a};

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q   <= {(4+KEY_W){1'b1}};
      pin_s2_q   <= {(4+KEY_W){1'b1}};
      pin_prev_q <= 4'hF;
    end else begin
      pin_s1_q   <= pins_raw;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  reg [N-1:0] req_q;
  reg [N-1:0] en_q;
  reg [3:0]   pol_q;
  reg [3:0]   mode_q;

  // Polarity 1 selects rising; detector compares pin XOR inverted polarity, and a polarity write loads both sides so it raises no edge
  reg  [3:0] pol_q_prev;
  wire [3:0] lvl_now  = pin_s2_q[3:0] ^ ~pol_q;
  wire [3:0] lvl_prev = pin_prev_q ^ ~pol_q_prev;
  wire [3:0] pin_edge = lvl_now & ~lvl_prev;

  wire sleeping = stop_mode_q | wait_mode_q;
  wire key_low  = ~&pin_s2_q[4+KEY_W-1:4];
  wire key_evt  = sleeping & mode_q[`IAW_MODE_KEY_SEL] & key_low;

  wire [N-1:0] evt = {key_evt, adc_evt, arb_evt, stx_evt, srx_evt, tmr2_evt, tmr1_evt,
                      tmry_evt, tmrx_evt, pin_edge};

  // Stop-mode wakeup qualification; every source but break wakes wait
  wire [N-1:0] stop_ok;
  assign stop_ok[3:0]  = 4'hF;
  assign stop_ok[`IAW_SRC_TMRX] = mode_q[`IAW_MODE_TMRX_EVT];
  assign stop_ok[`IAW_SRC_TMRY] = mode_q[`IAW_MODE_TMRY_EVT];
  assign stop_ok[`IAW_SRC_TMR1] = 1'b0;
  assign stop_ok[`IAW_SRC_TMR2] = 1'b0;
  assign stop_ok[`IAW_SRC_SRX]  = mode_q[`IAW_MODE_SER_EXT];
  assign stop_ok[`IAW_SRC_STX]  = mode_q[`IAW_MODE_SER_EXT];
  assign stop_ok[`IAW_SRC_ARB]  = mode_q[`IAW_MODE_SER_EXT];
  assign stop_ok[`IAW_SRC_ADC]  = 1'b0;
  assign stop_ok[`IAW_SRC_KEY]  = 1'b1;

  wire [N-1:0] pend = req_q & en_q;

  // Fixed priority: lowest index wins
  reg [`IAW_VEC_W-1:0] win_idx;
  reg                  win_any;
  integer i;
  always @* begin
    win_idx = {`IAW_VEC_W{1'b0}};
    win_any = 1'b0;
    for (i = N-1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        win_idx = i[`IAW_VEC_W-1:0];
        win_any = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer
  reg [2:0]  st_q;
  reg [15:0] pc_q;
  reg [7:0]  ps_q;
  reg [`IAW_VEC_W-1:0] acc_idx_q;
  reg        acc_brk_q;

  wire boundary_ok = insn_boundary & (st_q == `IAW_ST_IDLE) & ~seq_busy_q;
  wire take_irq    = boundary_ok & win_any & ~disable_q;
  wire take_brk    = boundary_ok & software_break_instruction & ~take_irq;
  wire take_rti    = boundary_ok & return_from_interrupt_instruction & ~take_irq;
  // Break under disable with pending source vectors to that source
  wire brk_to_src  = take_brk & win_any;
  wire [N-1:0] acc_clr = (take_irq | brk_to_src) ? ({{(N-1){1'b0}}, 1'b1} << win_idx) : {N{1'b0}};

  wire wake_stop = stop_mode_q & |(pend & stop_ok);
  wire wake_wait = wait_mode_q & |pend;

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= `IAW_ST_IDLE;
      pc_q         <= 16'h0000;
      ps_q         <= 8'h00;
      acc_idx_q    <= {`IAW_VEC_W{1'b0}};
      acc_brk_q    <= 1'b0;
      seq_busy_q   <= 1'b0;
      push_valid_q <= 1'b0;
      push_data_q  <= 8'h00;
      pop_req_q    <= 1'b0;
      vec_valid_q  <= 1'b0;
      vec_q        <= {`IAW_VEC_W{1'b0}};
      pc_out_q     <= 16'h0000;
      pc_load_q    <= 1'b0;
      disable_q    <= 1'b1;
      break_flag_q <= 1'b0;
      stop_mode_q  <= 1'b0;
      wait_mode_q  <= 1'b0;
    end else begin
      push_valid_q <= 1'b0;
      pop_req_q    <= 1'b0;
      vec_valid_q  <= 1'b0;
      pc_load_q    <= 1'b0;
      if (wake_stop | wake_wait) begin
        stop_mode_q <= 1'b0;
        wait_mode_q <= 1'b0;
      end else if (boundary_ok & stop_instruction) begin
        stop_mode_q <= 1'b1;
      end else if (boundary_ok & wait_instruction) begin
        wait_mode_q <= 1'b1;
      end
      if (clr_disable & st_q == `IAW_ST_IDLE) begin
        disable_q <= 1'b0;
      end else if (set_disable & st_q == `IAW_ST_IDLE) begin
        disable_q <= 1'b1;
      end
      case (st_q)
        `IAW_ST_IDLE: begin
          if (take_irq | take_brk) begin
            st_q       <= `IAW_ST_PCH;
            seq_busy_q <= 1'b1;
            pc_q       <= take_brk ? pc_in + `IAW_BRK_PC_INC : pc_in;
            ps_q       <= status_in;
            acc_idx_q  <= (take_irq | brk_to_src) ? win_idx : `IAW_VEC_BREAK;
            acc_brk_q  <= take_brk;
            break_flag_q <= take_brk;
          end else if (take_rti) begin
            st_q       <= `IAW_ST_RPS;
            seq_busy_q <= 1'b1;
            pop_req_q  <= 1'b1;
          end
        end
        `IAW_ST_PCH: begin
          push_valid_q <= 1'b1;
          push_data_q  <= pc_q[15:8];
          st_q         <= `IAW_ST_PCL;
        end
        `IAW_ST_PCL: begin
          push_valid_q <= 1'b1;
          push_data_q  <= pc_q[7:0];
          st_q         <= `IAW_ST_PS;
        end
        `IAW_ST_PS: begin
          push_valid_q <= 1'b1;
          push_data_q  <= ps_q;
          st_q         <= `IAW_ST_VEC;
        end
        `IAW_ST_VEC: begin
          vec_valid_q  <= 1'b1;
          vec_q        <= acc_idx_q;
          disable_q    <= 1'b1;
          seq_busy_q   <= 1'b0;
          st_q         <= `IAW_ST_IDLE;
        end
        // Return pulls status, then PC low, then PC high
        `IAW_ST_RPS: begin
          disable_q    <= pop_data[`IAW_PS_DIS_BIT];
          break_flag_q <= pop_data[`IAW_PS_BRK_BIT];
          pop_req_q    <= 1'b1;
          st_q         <= `IAW_ST_RPCL;
        end
        `IAW_ST_RPCL: begin
          pc_q[7:0]    <= pop_data;
          pop_req_q    <= 1'b1;
          st_q         <= `IAW_ST_RPCH;
        end
        `IAW_ST_RPCH: begin
          pc_out_q     <= {pop_data, pc_q[7:0]};
          pc_load_q    <= 1'b1;
          seq_busy_q   <= 1'b0;
          st_q         <= `IAW_ST_IDLE;
        end
        default: st_q <= `IAW_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; accepts a write only when address and data are both present
  wire wr_go = s_awvalid & s_wvalid & ~s_bvalid;
  assign s_awready = wr_go;
  assign s_wready  = wr_go;
  wire rd_go = s_arvalid & ~s_rvalid;
  assign s_arready = rd_go;
  wire wr_map = (s_awaddr == `IAW_REG_REQ) | (s_awaddr == `IAW_REG_EN) |
                (s_awaddr == `IAW_REG_POL) | (s_awaddr == `IAW_REG_MODE);
  wire [31:0] wmask = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
  wire [31:0] wclr  = s_wdata | ~wmask;
  wire req_wr = wr_go & (s_awaddr == `IAW_REG_REQ);

  // Event set wins over software clear and acceptance clear
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_req
      always @(posedge aclk) begin
        if (!aresetn) begin
          req_q[g] <= 1'b0;
        end else if (evt[g]) begin
          req_q[g] <= 1'b1;
        end else if (acc_clr[g] | (req_wr & ~wclr[g])) begin
          req_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      en_q       <= {N{1'b0}};
      pol_q      <= 4'h0;
      pol_q_prev <= 4'h0;
      mode_q     <= 4'h0;
      s_bvalid   <= 1'b0;
      s_bresp    <= `IAW_RESP_OKAY;
      s_rvalid   <= 1'b0;
      s_rresp    <= `IAW_RESP_OKAY;
      s_rdata    <= 32'h00000000;
    end else begin
      pol_q_prev <= pol_q;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_map ? `IAW_RESP_OKAY : `IAW_RESP_SLVERR;
        if (s_awaddr == `IAW_REG_EN) begin
          en_q <= (en_q & ~wmask[N-1:0]) | (s_wdata[N-1:0] & wmask[N-1:0]);
        end
        if (s_awaddr == `IAW_REG_POL & s_wstrb[0]) begin
          pol_q      <= s_wdata[3:0];
          pol_q_prev <= s_wdata[3:0];
        end
        if (s_awaddr == `IAW_REG_MODE & s_wstrb[0]) begin
          mode_q <= s_wdata[3:0];
        end
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rresp  <= `IAW_RESP_OKAY;
        case (s_araddr)
          `IAW_REG_REQ:  s_rdata <= {{(32-N){1'b0}}, req_q};
          `IAW_REG_EN:   s_rdata <= {{(32-N){1'b0}}, en_q};
          `IAW_REG_POL:  s_rdata <= {28'h0000000, pol_q};
          `IAW_REG_MODE: s_rdata <= {28'h0000000, mode_q};
          default: begin
            s_rdata <= 32'h00000000;
            s_rresp <= `IAW_RESP_SLVERR;
          end
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: verif/iaw_props.sv
// Port-level assertions for the interrupt acceptance block
`timescale 1ns/1ns
`default_nettype none
`include "iaw_defs.vh"
module iaw_props (
  // Clock, reset and core requests
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        insn_boundary,
  input wire logic        software_break_instruction,
  input wire logic        return_from_interrupt_instruction,
  input wire logic        clr_disable,
  input wire logic [15:0] pc_in,
  // Sequencer outputs
  input wire logic        seq_busy_q,
  input wire logic        push_valid_q,
  input wire logic [7:0]  push_data_q,
  input wire logic        pop_req_q,
  input wire logic        vec_valid_q,
  input wire logic        pc_load_q,
  input wire logic        disable_q,
  input wire logic        stop_mode_q,
  input wire logic        wait_mode_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire idle_bd = insn_boundary && !seq_busy_q;
  wire swb     = idle_bd && software_break_instruction;
  property p_push_order;
    $rose(push_valid_q) |=> push_valid_q ##1 push_valid_q ##1 (vec_valid_q && !push_valid_q);
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order wrong");
  property p_at_boundary;
    $rose(push_valid_q) |-> $past(idle_bd, 2);
  endproperty
  a_at_boundary: assert property (p_at_boundary) else $error("accepted off a boundary");
  property p_masked;
    idle_bd && disable_q && !software_break_instruction && !clr_disable |-> ##2 !push_valid_q;
  endproperty
  a_masked: assert property (p_masked) else $error("accepted while disabled");
  property p_swb_pc;
    swb && disable_q |-> ##2 (push_valid_q && push_data_q == 8'(($past(pc_in, 2) + `IAW_BRK_PC_INC) >> 8));
  endproperty
  a_swb_pc: assert property (p_swb_pc) else $error("break pushed wrong pc");
  property p_swb_vec;
    swb |-> ##5 vec_valid_q;
  endproperty
  a_swb_vec: assert property (p_swb_vec) else $error("break not accepted");
  property p_vec_dis;
    vec_valid_q |-> disable_q;
  endproperty
  a_vec_dis: assert property (p_vec_dis) else $error("disable not set on vector");
  property p_awake;
    vec_valid_q |-> !stop_mode_q && !wait_mode_q;
  endproperty
  a_awake: assert property (p_awake) else $error("vector while sleeping");
  property p_return;
    idle_bd && return_from_interrupt_instruction && !software_break_instruction
      |=> pop_req_q [*3] ##1 (pc_load_q && !pop_req_q);
  endproperty
  a_return: assert property (p_return) else $error("return pull order wrong");
endmodule
bind iaw_top iaw_props u_props (.aclk, .aresetn, .insn_boundary, .software_break_instruction,
  .return_from_interrupt_instruction, .clr_disable, .pc_in, .seq_busy_q, .push_valid_q, .push_data_q,
  .pop_req_q, .vec_valid_q, .pc_load_q, .disable_q, .stop_mode_q, .wait_mode_q);
`default_nettype wire

// file: verif/iaw_core_model.sv
// Stack memory standing in for the core's push and pull path
`timescale 1ns/1ns
`default_nettype none
module iaw_core_model (
  input wire logic       aclk,
  input wire logic       push_valid_q,
  input wire logic [7:0] push_data_q,
  input wire logic       pop_req_q,
  output var logic [7:0] pop_data
);
  logic [7:0] stk_q [0:7];
  logic [2:0] sp_q = 3'h0;
  always @(posedge aclk) begin
    if (push_valid_q) begin
      stk_q[sp_q] <= push_data_q;
      sp_q        <= sp_q + 3'h1;
    end
    if (pop_req_q) begin
      sp_q <= sp_q - 3'h1;
    end
  end
  // Top byte stands in the pull cycle itself; otherwise its inverse, so a stray read never looks valid
  always_comb pop_data = pop_req_q ? stk_q[sp_q - 3'h1] : ~stk_q[sp_q - 3'h1];
endmodule
`default_nettype wire

// file: verif/iaw_top_tb_top.sv
// Self-checking bench for the interrupt acceptance block
`timescale 1ns/1ns
`default_nettype none
`include "iaw_defs.vh"
module iaw_top_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
  logic        insn_boundary = 1'b0, clr_disable = 1'b0, set_disable = 1'b0;
  logic [3:0]  s_awaddr = 4'h0, s_araddr = 4'h0, pins = 4'hF, ins = 4'h0;
  logic [7:0]  tev = 8'h00, keypad_port = 8'hFF, status_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [31:0] s_wdata = 32'h0;
  wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, seq_busy_q, push_valid_q, pop_req_q;
  wire         vec_valid_q, pc_load_q, disable_q, break_flag_q, stop_mode_q, wait_mode_q;
  wire [1:0]   s_bresp, s_rresp;
  wire [7:0]   pop_data, push_data_q;
  wire [15:0]  pc_out_q;
  wire [31:0]  s_rdata;
  wire [`IAW_VEC_W-1:0] vec_q;
  int          failures = 0, tests_run = 0, cycles = 0, seed = 32'h14F5;
  logic [33:0] exp_q [$];
  iaw_top #(.KEY_W(8)) u_dut (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready(1'b1), .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready(1'b1), .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .counter_pin_a(pins[2]),
    .counter_pin_b(pins[3]), .keypad_port, .tmrx_evt(tev[0]), .tmry_evt(tev[1]), .tmr1_evt(tev[2]),
    .tmr2_evt(tev[3]), .srx_evt(tev[4]), .stx_evt(tev[5]), .arb_evt(tev[6]), .adc_evt(tev[7]),
    .insn_boundary, .software_break_instruction(ins[3]), .return_from_interrupt_instruction(ins[2]),
    .stop_instruction(ins[1]), .wait_instruction(ins[0]), .clr_disable, .set_disable, .pc_in, .status_in,
    .pop_data, .seq_busy_q, .push_valid_q, .push_data_q, .pop_req_q, .vec_valid_q, .vec_q, .pc_out_q,
    .pc_load_q, .disable_q, .break_flag_q, .stop_mode_q, .wait_mode_q);
  iaw_core_model u_core (.aclk, .push_valid_q, .push_data_q, .pop_req_q, .pop_data);
  initial forever #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [33:0] e, logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Results arrive strictly in issue order, so one queue serves all kinds
  always @(posedge aclk) begin
    cycles++;
    if (s_rvalid || push_valid_q || vec_valid_q || pc_load_q)
      chk("result", exp_q.size() ? exp_q.pop_front() : 'x, s_rvalid ? {s_rresp, s_rdata} :
          push_valid_q ? push_data_q : vec_valid_q ? vec_q : pc_out_q);
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do @(posedge aclk); while (!s_awready);
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_bvalid);
    chk("bresp", `IAW_RESP_OKAY, s_bresp);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = `IAW_RESP_OKAY);
    exp_q.push_back({r, d});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
  endtask
  task automatic step(input logic [3:0] k);
    insn_boundary <= 1'b1;
    ins <= k;
    @(posedge aclk);
    insn_boundary <= 1'b0;
    ins <= 4'h0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic take(input logic [3:0] v, input logic [3:0] k, input logic [7:0] st);
    logic [15:0] p;
    p = 16'($random(seed));
    pc_in <= p;
    status_in <= st;
    if (k[3])
      p = p + `IAW_BRK_PC_INC;
    exp_q.push_back(p[15:8]);
    exp_q.push_back(p[7:0]);
    exp_q.push_back(st);
    exp_q.push_back(v);
    step(k);
    exp_q.push_back(p);
    step(4'h4);
  endtask
  task automatic pulse(input logic [7:0] t);
    tev <= t;
    @(posedge aclk);
    tev <= 8'h00;
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("disable_q", 1'b1, disable_q);
    for (int i = 0; i < 4; i++)
      rd(4'(i * 4), 32'h0);
    rd(4'h2, 32'h0, `IAW_RESP_SLVERR);
    $display("reset test done");
    pulse(8'h04);
    wr(`IAW_REG_REQ, 32'hFFFFFFFF);
    @(posedge aclk);
    rd(`IAW_REG_REQ, 32'h40);
    wr(`IAW_REG_REQ, 32'h0);
    @(posedge aclk);
    rd(`IAW_REG_REQ, 32'h0);
    $display("request write test done");
    wr(`IAW_REG_EN, 32'h880);
    pulse(8'h8C);
    step(4'h0);
    clr_disable <= 1'b1;
    @(posedge aclk);
    clr_disable <= 1'b0;
    @(posedge aclk);
    take(`IAW_SRC_TMR2, 4'h0, 8'h00);
    rd(`IAW_REG_REQ, 32'h840);
    chk("disable_q", 1'b0, disable_q);
    take(`IAW_SRC_ADC, 4'h0, 8'h00);
    $display("priority test done");
    set_disable <= 1'b1;
    @(posedge aclk);
    set_disable <= 1'b0;
    @(posedge aclk);
    take(`IAW_VEC_BREAK, 4'h8, 8'h14);
    chk("break_flag_q", 1'b1, break_flag_q);
    pulse(8'h08);
    take(`IAW_SRC_TMR2, 4'h8, 8'h14);
    rd(`IAW_REG_REQ, 32'h40);
    $display("break test done");
    pins <= 4'hF;
    repeat (6) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      if (i == 4)
        wr(`IAW_REG_POL, 32'hF);
      wr(`IAW_REG_REQ, 32'h0);
      pins[i % 4] <= ~pins[i % 4];
      repeat (6) @(posedge aclk);
      rd(`IAW_REG_REQ, 32'h1 << (i % 4));
    end
    wr(`IAW_REG_REQ, 32'h0);
    $display("edge test done");
    wr(`IAW_REG_MODE, 32'h8);
    wr(`IAW_REG_EN, 32'h1000);
    keypad_port <= 8'hFE;
    repeat (6) @(posedge aclk);
    rd(`IAW_REG_REQ, 32'h0);
    keypad_port <= 8'hFF;
    repeat (6) @(posedge aclk);
    step(4'h1);
    chk("wait_mode_q", 1'b1, wait_mode_q);
    keypad_port <= 8'(~(8'h1 << ($random(seed) & 7)));
    repeat (8) @(posedge aclk);
    chk("wait_mode_q", 1'b0, wait_mode_q);
    keypad_port <= 8'hFF;
    wr(`IAW_REG_EN, 32'h50);
    wr(`IAW_REG_REQ, 32'h0);
    step(4'h2);
    pulse(8'h04);
    repeat (4) @(posedge aclk);
    chk("stop_mode_q", 1'b1, stop_mode_q);
    wr(`IAW_REG_MODE, 32'h1);
    pulse(8'h01);
    repeat (4) @(posedge aclk);
    chk("stop_mode_q", 1'b0, stop_mode_q);
    $display("wakeup test done");
    final_report();
  end
endmodule
`default_nettype wire
